// File: src/cstat_pkg.sv
// package for the contactless status register block
// ****************************************************************
// Function
// - bit 30 shows phase loop switched on
// - bit 29 field lost during load modulation
// - bit 28 crc zero or residue
// - bit 27 follows live subcarrier detector
// - bit 26 start of frame recognised
// - bit 25 own antenna drivers on
// - bit 24 filtered external field present
// - bit 15 running on fallback clock
// - bit 14 buffer transfer in progress
// - bits 10:8 fault cause, codes 0-4
// - fault codes 5-7 unused, shown as 0
// - bit 5 receive decoder armed
// - bit 4 transmit encoder sending
// - bit 3 receive decoder receiving
// - bits 2:0 transceive sequencer state
// ****************************************************************
package cstat_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] STATUS_OFF = 12'h008;
    localparam logic [11:0] CTRL_OFF = 12'h020;
    localparam logic [31:0] STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0003;

    // ************************************************************
    // status field positions
    // ************************************************************
    localparam int LOOP_ON_BIT = 30;
    localparam int FIELD_LOSS_BIT = 29;
    localparam int CRC_OK_BIT = 28;
    localparam int SUBCARRIER_BIT = 27;
    localparam int SOF_BIT = 26;
    localparam int OWN_FIELD_BIT = 25;
    localparam int EXT_FIELD_BIT = 24;
    localparam int FALLBACK_CLK_BIT = 15;
    localparam int BUF_BUSY_BIT = 14;
    localparam int TX_READ_FAULT_BIT = 13;
    localparam int TX_LATE_FAULT_BIT = 12;
    localparam int TX_NO_DATA_BIT = 11;
    localparam int FAULT_CODE_LSB = 8;
    localparam int RX_ARMED_BIT = 5;
    localparam int TX_BUSY_BIT = 4;
    localparam int RX_BUSY_BIT = 3;
    localparam int TRX_STATE_LSB = 0;

    // control bits
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_INV_BIT = 1;

    // ************************************************************
    // field activation fault codes
    // ************************************************************
    localparam logic [2:0] FAULT_NONE = 3'h0;
    localparam logic [2:0] FAULT_IN_INITIAL = 3'h1;
    localparam logic [2:0] FAULT_IN_ACTIVATION = 3'h2;
    localparam logic [2:0] FAULT_NO_FIELD = 3'h3;
    localparam logic [2:0] FAULT_PEER_DROP = 3'h4;

    // transceive sequencer codes
    localparam logic [2:0] TRX_IDLE = 3'h0;
    localparam logic [2:0] TRX_WAIT_TX = 3'h1;
    localparam logic [2:0] TRX_TX = 3'h2;
    localparam logic [2:0] TRX_WAIT_RX = 3'h3;
    localparam logic [2:0] TRX_WAIT_DATA = 3'h4;
    localparam logic [2:0] TRX_RX = 3'h5;
    localparam logic [2:0] TRX_WAIT_LOOP = 3'h6;
    localparam logic [2:0] TRX_LOOP = 3'h7;

    // ************************************************************
    // crc check and field filter
    // ************************************************************
    localparam int CRC_W = 16;
    localparam logic [15:0] CRC_RESIDUE = 16'h0f47;
    localparam int FILT_W = 3;
    localparam logic [2:0] FILT_LAST = 3'h3;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic {CSTAT_PH_IDLE, CSTAT_PH_ACCESS} cstat_ph_t;

    typedef struct packed {
        logic loop_on_flag;
        logic field_loss_during_tx;
        logic active_load_modulation_mode;
        logic [15:0] crc_value;
        logic subcarrier_seen;
        logic sof_seen;
        logic own_field_on;
        logic fallback_clk_active;
        logic buffer_transfer_busy;
        logic tx_read_fault;
        logic tx_late_fault;
        logic tx_no_data_fault;
        logic [2:0] field_activation_fault_code;
        logic rx_armed;
        logic tx_busy;
        logic rx_busy;
        logic [2:0] transceive_state;
    } cstat_src_t;

    typedef struct packed {
        logic [31:0] status;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic field_loss_detect_select;
        logic crc_inverted;
        cstat_ph_t ph;
    } cstat_main_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic [2:0] cnt;
        logic level;
    } cstat_filt_t;

    function automatic logic cstat_hit(input logic [11:0] a,
                                       input logic [11:0] off);
        return a == off;
    endfunction : cstat_hit

endpackage : cstat_pkg

// File: src/cstat_field_filter.sv
// external field level synchroniser and digital filter
`timescale 1ns/10ps
module cstat_field_filter
    import cstat_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic raw_level,
    output logic external_field_present
);
    cstat_filt_t st_ff;
    cstat_filt_t nxt_st;

    // ************************************************************
    // two stage sync, then count stable disagreeing samples
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = raw_level;
        nxt_st.s2 = st_ff.s1;
        if (st_ff.s2 == st_ff.level) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt == FILT_LAST) begin
            nxt_st.level = st_ff.s2;
            nxt_st.cnt = '0;
        end else begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign external_field_present = st_ff.level;

endmodule : cstat_field_filter

// File: src/cstat_crc_check.sv
// compares the running crc against zero or the residue
`timescale 1ns/10ps
module cstat_crc_check
    import cstat_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] crc_value,
    input wire logic crc_inverted,
    output logic crc_ok
);
    logic crc_ok_ff;
    logic nxt_crc_ok;

    always_comb begin
        if (crc_inverted) begin
            nxt_crc_ok = crc_value == CRC_RESIDUE;
        end else begin
            nxt_crc_ok = crc_value == '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            crc_ok_ff <= 1'b0;
        end else begin
            crc_ok_ff <= nxt_crc_ok;
        end
    end

    assign crc_ok = crc_ok_ff;

endmodule : cstat_crc_check

// File: src/cstat_top.sv
// contactless status word with apb slave and control register
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
module cstat_top
    import cstat_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cstat_src_t src,
    input wire logic ext_field_raw
);
    cstat_main_t st_ff;
    cstat_main_t nxt_st;
    logic crc_ok;
    logic ext_field;
    logic [31:0] word;
    logic [2:0] fault_code;
    logic setup;
    logic wr_done;

    // ************************************************************
    // helpers
    // ************************************************************
    cstat_crc_check u_crc (
        .clk(clk),
        .reset_n(reset_n),
        .crc_value(src.crc_value),
        .crc_inverted(st_ff.crc_inverted),
        .crc_ok(crc_ok)
    );

    cstat_field_filter u_filt (
        .clk(clk),
        .reset_n(reset_n),
        .raw_level(ext_field_raw),
        .external_field_present(ext_field)
    );

    // ************************************************************
    // status word assembly
    // ************************************************************
    always_comb begin
        if (src.field_activation_fault_code > FAULT_PEER_DROP) begin
            fault_code = FAULT_NONE;
        end else begin
            fault_code = src.field_activation_fault_code;
        end
    end

    always_comb begin
        word = '0;
        word[LOOP_ON_BIT] = src.loop_on_flag;
        word[FIELD_LOSS_BIT] = src.field_loss_during_tx
            & src.active_load_modulation_mode
            & st_ff.field_loss_detect_select;
        word[CRC_OK_BIT] = crc_ok;
        word[SUBCARRIER_BIT] = src.subcarrier_seen;
        word[SOF_BIT] = src.sof_seen;
        word[OWN_FIELD_BIT] = src.own_field_on;
        word[EXT_FIELD_BIT] = ext_field;
        word[FALLBACK_CLK_BIT] = src.fallback_clk_active;
        word[BUF_BUSY_BIT] = src.buffer_transfer_busy;
        word[TX_READ_FAULT_BIT] = src.tx_read_fault;
        word[TX_LATE_FAULT_BIT] = src.tx_late_fault;
        word[TX_NO_DATA_BIT] = src.tx_no_data_fault;
        word[FAULT_CODE_LSB +: 3] = fault_code;
        word[RX_ARMED_BIT] = src.rx_armed;
        word[TX_BUSY_BIT] = src.tx_busy;
        word[RX_BUSY_BIT] = src.rx_busy;
        word[TRX_STATE_LSB +: 3] = src.transceive_state;
    end

    // ************************************************************
    // apb slave, one wait-free access phase
    // ************************************************************
    assign setup = psel & ~penable;
    assign wr_done = psel & penable & pwrite & st_ff.pready;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.status = word;
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
        case (st_ff.ph)
            CSTAT_PH_IDLE: begin
                if (setup) begin
                    nxt_st.ph = CSTAT_PH_ACCESS;
                    nxt_st.pready = 1'b1;
                    nxt_st.prdata = '0;
                    if (cstat_hit(paddr, STATUS_OFF)) begin
                        if (!pwrite) begin
                            nxt_st.prdata = st_ff.status;
                        end
                    end else if (cstat_hit(paddr, CTRL_OFF)) begin
                        if (!pwrite) begin
                            nxt_st.prdata[CTRL_SEL_BIT] =
                                st_ff.field_loss_detect_select;
                            nxt_st.prdata[CTRL_INV_BIT] =
                                st_ff.crc_inverted;
                        end
                    end else begin
                        nxt_st.pslverr = 1'b1;
                    end
                end
            end
            CSTAT_PH_ACCESS: begin
                nxt_st.ph = CSTAT_PH_IDLE;
                // writes to the status word fall through unheard
                if (wr_done && cstat_hit(paddr, CTRL_OFF)) begin
                    nxt_st.field_loss_detect_select = pwdata[CTRL_SEL_BIT];
                    nxt_st.crc_inverted = pwdata[CTRL_INV_BIT];
                end
            end
            default: begin
                nxt_st.ph = CSTAT_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_loop_on_bit: assert property (
        src.loop_on_flag |=> st_ff.status[LOOP_ON_BIT])
        else $error("loop on flag not shown");

    chk_field_loss_gate: assert property (
        !st_ff.field_loss_detect_select
        |=> !st_ff.status[FIELD_LOSS_BIT])
        else $error("field loss shown while select off");

    chk_crc_zero: assert property (
        (src.crc_value == '0 && !st_ff.crc_inverted
         && !nxt_st.crc_inverted)
        ##1 1'b1 |=> st_ff.status[CRC_OK_BIT])
        else $error("crc zero not reported");

    chk_subcarrier_bit: assert property (
        st_ff.status[SUBCARRIER_BIT] == $past(src.subcarrier_seen))
        else $error("subcarrier bit stale");

    chk_sof_own_bits: assert property (
        ##1 st_ff.status[OWN_FIELD_BIT +: 2]
        == {$past(src.sof_seen), $past(src.own_field_on)})
        else $error("sof or own field bit wrong");

    chk_ext_field_lag: assert property (
        $rose(st_ff.status[EXT_FIELD_BIT])
        |-> $past(ext_field_raw, 7) && $past(ext_field_raw, 4))
        else $error("external field rose without stable level");

    chk_fallback_buf: assert property (
        (src.fallback_clk_active && src.buffer_transfer_busy)
        |=> st_ff.status[FALLBACK_CLK_BIT]
            && st_ff.status[BUF_BUSY_BIT])
        else $error("clock or buffer bit missing");

    chk_fault_unused: assert property (
        st_ff.status[FAULT_CODE_LSB +: 3] <= FAULT_PEER_DROP)
        else $error("unused fault code shown");

    chk_fault_pass: assert property (
        (src.field_activation_fault_code == FAULT_IN_ACTIVATION)
        |=> st_ff.status[FAULT_CODE_LSB +: 3] == FAULT_IN_ACTIVATION)
        else $error("fault code not passed");

    chk_activity_bits: assert property (
        ##1 st_ff.status[RX_BUSY_BIT +: 3] == {$past(src.rx_armed),
            $past(src.tx_busy), $past(src.rx_busy)})
        else $error("activity bits wrong");

    chk_trx_state: assert property (
        ##1 st_ff.status[2:0] == $past(src.transceive_state))
        else $error("sequencer state wrong");

    chk_reserved_zero: assert property (
        st_ff.status[31] == 1'b0 && st_ff.status[23:16] == '0
        && st_ff.status[7:6] == '0)
        else $error("reserved bits not zero");

    chk_read_data: assert property (
        (setup && !pwrite && cstat_hit(paddr, STATUS_OFF))
        |=> pready && prdata == $past(st_ff.status))
        else $error("status read data wrong");

    chk_field_loss_set: assert property (
        (src.field_loss_during_tx && src.active_load_modulation_mode
         && st_ff.field_loss_detect_select)
        |=> st_ff.status[FIELD_LOSS_BIT])
        else $error("field loss not shown");

    chk_crc_residue: assert property (
        (src.crc_value == CRC_RESIDUE && st_ff.crc_inverted)
        ##1 1'b1 |=> st_ff.status[CRC_OK_BIT])
        else $error("crc residue not reported");

    chk_own_field_bit: assert property (
        src.own_field_on |=> st_ff.status[OWN_FIELD_BIT])
        else $error("own field bit missing");

    chk_ext_field_fall: assert property (
        $fell(st_ff.status[EXT_FIELD_BIT])
        |-> !$past(ext_field_raw, 7) && !$past(ext_field_raw, 4))
        else $error("external field fell without stable level");

    chk_buf_idle: assert property (
        !src.buffer_transfer_busy |=> !st_ff.status[BUF_BUSY_BIT])
        else $error("buffer busy shown while idle");

    chk_fault_peer: assert property (
        (src.field_activation_fault_code == FAULT_PEER_DROP)
        |=> st_ff.status[FAULT_CODE_LSB +: 3] == FAULT_PEER_DROP)
        else $error("peer drop code not passed");

    chk_status_write: assert property (
        (wr_done && cstat_hit(paddr, STATUS_OFF))
        |=> $stable({st_ff.field_loss_detect_select, st_ff.crc_inverted}))
        else $error("status write changed control");

    chk_bad_addr_err: assert property (
        (setup && st_ff.ph == CSTAT_PH_IDLE
         && !cstat_hit(paddr, STATUS_OFF)
         && !cstat_hit(paddr, CTRL_OFF))
        |=> pready && pslverr && prdata == '0)
        else $error("unmapped access not refused");

    cov_status_read: cover property (
        setup && !pwrite && cstat_hit(paddr, STATUS_OFF) ##1 pready);
    cov_ctrl_write: cover property (wr_done && cstat_hit(paddr, CTRL_OFF));
    cov_bad_addr: cover property (pslverr);
    cov_field_loss: cover property (st_ff.status[FIELD_LOSS_BIT]);
    cov_ext_field: cover property ($rose(st_ff.status[EXT_FIELD_BIT]));

endmodule : cstat_top

// File: verif/tb.sv
// testbench for the contactless status register block
`timescale 1ns/10ps
module tb;
    import cstat_pkg::*;

    // ************************************************************
    // signals
    // ************************************************************
    logic clk;
    logic reset_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cstat_src_t src;
    cstat_src_t s;
    logic ext_field_raw;
    int failures;
    int checks;

    cstat_top cstat_top_i (
        .clk(clk),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .src(src),
        .ext_field_raw(ext_field_raw)
    );

    always #20 clk = ~clk;

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // apb transfer, answer sampled at the rising edge ending access
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n <= 50) begin
            n++;
            @(posedge clk);
        end
        if (n > 50) begin
            failures++;
            $display("CHECK FAILED pready expected 1 seen 0");
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string n, input logic [11:0] a,
                          input logic [31:0] e, input logic ee);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0000_0000, rd, er);
        chk(n, e, rd);
        chk({n, " err"}, {31'h0, ee}, {31'h0, er});
    endtask : rd_chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic ee);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
        chk("write err", {31'h0, ee}, {31'h0, er});
    endtask : wr

    task automatic put_src(input cstat_src_t v);
        @(posedge clk);
        src <= v;
        repeat (3) @(posedge clk);
    endtask : put_src

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        rd_chk("status reset", 12'h008, 32'h0000_0000, 1'b0);
        rd_chk("ctrl reset", 12'h020, 32'h0000_0000, 1'b0);
    endtask : t_reset

    task automatic t_single_bits();
        int b;
        for (int i = 0; i < 16; i++) begin
            s = '0;
            s.crc_value = 16'h0001;
            b = -1;
            case (i)
                0: begin s.loop_on_flag = 1'b1; b = 30; end
                1: begin s.subcarrier_seen = 1'b1; b = 27; end
                2: begin s.sof_seen = 1'b1; b = 26; end
                3: begin s.own_field_on = 1'b1; b = 25; end
                4: begin s.fallback_clk_active = 1'b1; b = 15; end
                5: begin s.buffer_transfer_busy = 1'b1; b = 14; end
                6: begin s.tx_read_fault = 1'b1; b = 13; end
                7: begin s.tx_late_fault = 1'b1; b = 12; end
                8: begin s.tx_no_data_fault = 1'b1; b = 11; end
                9: begin s.rx_armed = 1'b1; b = 5; end
                10: begin s.tx_busy = 1'b1; b = 4; end
                11: begin s.rx_busy = 1'b1; b = 3; end
                default: begin end
            endcase
            put_src(s);
            if (b >= 0) begin
                rd_chk("single bit", 12'h008, 32'h1 << b, 1'b0);
            end else begin
                rd_chk("all clear", 12'h008, 32'h0, 1'b0);
            end
        end
    endtask : t_single_bits

    task automatic t_codes();
        logic [31:0] e;
        for (int c = 0; c < 8; c++) begin
            s = '0;
            s.crc_value = 16'h0001;
            s.field_activation_fault_code = c[2:0];
            s.transceive_state = c[2:0];
            put_src(s);
            e = {21'h0, (c < 5) ? c[2:0] : 3'h0, 5'h0, c[2:0]};
            rd_chk("codes", 12'h008, e, 1'b0);
        end
    endtask : t_codes

    task automatic t_crc();
        s = '0;
        put_src(s);
        rd_chk("crc zero", 12'h008, 32'h1000_0000, 1'b0);
        s.crc_value = CRC_RESIDUE;
        put_src(s);
        rd_chk("crc residue plain", 12'h008, 32'h0, 1'b0);
        wr(12'h020, 32'h0000_0002, 1'b0);
        repeat (3) @(posedge clk);
        rd_chk("crc residue inv", 12'h008, 32'h1000_0000, 1'b0);
        s.crc_value = 16'h0000;
        put_src(s);
        rd_chk("crc zero inv", 12'h008, 32'h0, 1'b0);
        wr(12'h020, 32'h0000_0000, 1'b0);
    endtask : t_crc

    task automatic t_field_loss();
        s = '0;
        s.crc_value = 16'h0001;
        s.field_loss_during_tx = 1'b1;
        s.active_load_modulation_mode = 1'b1;
        put_src(s);
        rd_chk("loss unselected", 12'h008, 32'h0, 1'b0);
        wr(12'h020, 32'hffff_ffff, 1'b0);
        rd_chk("ctrl readback", 12'h020, 32'h0000_0003, 1'b0);
        wr(12'h020, 32'h0000_0001, 1'b0);
        repeat (3) @(posedge clk);
        rd_chk("loss selected", 12'h008, 32'h2000_0000, 1'b0);
        s.active_load_modulation_mode = 1'b0;
        put_src(s);
        rd_chk("loss no load mod", 12'h008, 32'h0, 1'b0);
        wr(12'h020, 32'h0000_0000, 1'b0);
    endtask : t_field_loss

    task automatic t_ext_field();
        s = '0;
        s.crc_value = 16'h0001;
        put_src(s);
        @(posedge clk);
        ext_field_raw <= 1'b1;
        repeat (2) @(posedge clk);
        ext_field_raw <= 1'b0;
        repeat (12) @(posedge clk);
        rd_chk("field glitch", 12'h008, 32'h0, 1'b0);
        ext_field_raw <= 1'b1;
        repeat (12) @(posedge clk);
        rd_chk("field present", 12'h008, 32'h0100_0000, 1'b0);
        ext_field_raw <= 1'b0;
        repeat (12) @(posedge clk);
        rd_chk("field gone", 12'h008, 32'h0, 1'b0);
    endtask : t_ext_field

    task automatic t_read_only();
        s = '0;
        s.crc_value = 16'h0001;
        s.tx_busy = 1'b1;
        put_src(s);
        wr(12'h008, 32'hffff_ffff, 1'b0);
        rd_chk("status after write", 12'h008, 32'h0000_0010, 1'b0);
        rd_chk("unmapped read", 12'h004, 32'h0, 1'b1);
        wr(12'h004, 32'hffff_ffff, 1'b1);
    endtask : t_read_only

    task automatic t_mid_reset();
        s = '0;
        s.crc_value = 16'h0001;
        put_src(s);
        wr(12'h020, 32'h0000_0003, 1'b0);
        rd_chk("ctrl before reset", 12'h020, 32'h0000_0003, 1'b0);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk("ctrl after reset", 12'h020, 32'h0000_0000, 1'b0);
        rd_chk("status after reset", 12'h008, 32'h0, 1'b0);
    endtask : t_mid_reset

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        src = '0;
        src.crc_value = 16'h0001;
        ext_field_raw = 1'b0;
        failures = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_single_bits();
        t_codes();
        t_crc();
        t_field_loss();
        t_ext_field();
        t_read_only();
        t_mid_reset();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test();
    end

endmodule : tb
